// ===== inc/acs_pkg.sv
// constants for the converter control and summation unit
// assumes an 8-bit special-function register port on the core clock
// Behaviour
// - overflow or underflow sets sticky flag; write zero clears
// - polarity bit picks bipolar or unipolar coding
// - short variant spans 0x8000..0x7FFF, sign extended upward
// - top byte zeros if positive, ones if negative
// - two-bit field selects the digital filter
// - calibration field write starts calibration, reads zero
// - eleven-bit decimation from two registers
// - output rate is modulator rate over decimation
// - accumulator powered down with the converter
// - all-zero control write clears the accumulator
// - bipolar coding sign-extends added values
// - cpu sum mode adds byte registers on write
// - cpu subtract mode subtracts upper three accumulator bytes joined to written byte on write
// - mode bits pick shift, accumulate, or both
// - count completes after 2..256 results, raises interrupt
// - reading lowest byte clears pending interrupt
// - accumulator seen as four byte registers
// - offset code summed into converter input
// - offset codes 00h and 80h switch offset off
package acs_pkg;
	localparam logic [7:0] ADDR_CTRL1 = 8'hDD;
	localparam logic [7:0] ADDR_DEC_LO = 8'hDE;
	localparam logic [7:0] ADDR_DEC_HI = 8'hDF;
	localparam logic [7:0] ADDR_SSCTL = 8'hE1;
	localparam logic [7:0] ADDR_SUM0 = 8'hE2;
	localparam logic [7:0] ADDR_SUM1 = 8'hE3;
	localparam logic [7:0] ADDR_SUM2 = 8'hE4;
	localparam logic [7:0] ADDR_SUM3 = 8'hE5;
	localparam logic [7:0] ADDR_INPUT_OFFSET_CODE = 8'hE6;
	localparam logic [7:0] RST_CTRL1 = 8'h00;
	localparam logic [7:0] RST_DEC_LO = 8'h1B;
	localparam logic [2:0] RST_DEC_HI = 3'h6;
	localparam logic [7:0] RST_SSCTL = 8'h00;
	localparam logic [7:0] RST_INPUT_OFFSET_CODE = 8'h00;
	localparam int BIT_RANGE_ERR = 7;
	localparam int BIT_POLARITY = 6;
	localparam int SETTLE_LSB = 4;
	localparam int MODE_LSB = 6;
	localparam int CNT_LSB = 3;
	localparam int MOD_DIV = 64;
	localparam logic [7:0] INPUT_OFFSET_CODE_OFF_POS = 8'h00;
	localparam logic [7:0] INPUT_OFFSET_CODE_OFF_NEG = 8'h80;
	localparam logic [1:0] MODE_CPU = 2'h0;
	localparam logic [1:0] MODE_CONV = 2'h1;
	localparam logic [1:0] MODE_SHIFT = 2'h2;
	localparam logic [1:0] MODE_BOTH = 2'h3;
	localparam logic [2:0] CNT_CPU_ADD = 3'h2;
	localparam logic [2:0] CNT_CPU_SUB = 3'h4;
	typedef enum logic [1:0] {SETTLE_AUTO, SETTLE_FAST, SETTLE_SINC2, SETTLE_SINC3} acs_settle_t;
	typedef enum logic [2:0] {CAL_NONE, CAL_SELF_BOTH, CAL_SELF_OFS, CAL_SELF_GAIN,
		CAL_SYS_OFS, CAL_SYS_GAIN, CAL_RSV6, CAL_RSV7} acs_cal_t;
endpackage

// ===== rtl/acs_rate_gen.sv
// output-rate strobe generator for the converter
// assumes mclk is the system clock and aclk_div is stable between changes
`timescale 1ns/1ps
`default_nettype none
module acs_rate_gen (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// settings
	input  wire logic        enable,
	input  wire logic [7:0]  aclk_div,
	input  wire logic [10:0] decimation,
	// strobes
	output logic             mod_tick,
	output logic             data_tick
);
	logic [13:0] pre_q;
	logic [10:0] dec_q;
	logic [13:0] pre_top;
	logic        pre_wrap;
	logic        dec_wrap;

	// modulator period is 64 times divider plus one clocks
	assign pre_top  = 14'(acs_pkg::MOD_DIV * (int'(aclk_div) + 1) - 1);
	assign pre_wrap = (pre_q >= pre_top);
	assign dec_wrap = pre_wrap && (dec_q + 11'h001 >= decimation);

	//////////////////////////////////////////////////////////////////////
	// counters; a zero ratio behaves as a ratio of one
	always_ff @(posedge mclk) begin
		if (rst || !enable) begin
			pre_q     <= 14'h0000;
			dec_q     <= 11'h000;
			mod_tick  <= 1'b0;
			data_tick <= 1'b0;
		end else begin
			pre_q     <= pre_wrap ? 14'h0000 : pre_q + 14'h0001;
			mod_tick  <= pre_wrap;
			data_tick <= dec_wrap;
			if (pre_wrap) begin
				dec_q <= dec_wrap ? 11'h000 : dec_q + 11'h001;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/acs_top.sv
// converter control registers and 32-bit summation/shifter
// assumes a one-cycle sfr read/write port from the core, addresses 8 bits
`timescale 1ns/1ps
`default_nettype none
module acs_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// sfr port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic [7:0]       sfr_rdata,
	output logic             sfr_hit,
	// converter side
	input  wire logic        adc_powerdown,
	input  wire logic        short_variant,
	input  wire logic [7:0]  aclk_div,
	input  wire logic        result_valid,
	input  wire logic [23:0] result_raw,
	// control to the analog side
	output logic [1:0]       settling_select,
	output logic [2:0]       calibration_command,
	output logic             cal_start,
	output logic [10:0]      decimation_ratio,
	output logic             conv_tick,
	output logic [7:0]       offset_code,
	output logic             offset_enable,
	output logic [7:0]       result_top_byte,
	// event
	output logic             sum_irq
);
	logic        range_err_q;
	logic        polarity_q;
	logic [1:0]  settle_q;
	logic [7:0]  dec_lo_q;
	logic [2:0]  dec_hi_q;
	logic [7:0]  ssctl_q;
	logic [7:0]  input_offset_code_q;
	logic [31:0] acc_q;
	logic [31:0] acc_d;
	logic        acc_err_d;
	logic [8:0]  cnt_q;
	logic        sum_done_q;
	logic        shift_pend_q;
	logic        data_tick;
	logic        res_valid_q;
	logic [23:0] res_q;

	//////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [32:0] ext33(input logic [31:0] v, input logic sgn);
		ext33 = {sgn & v[31], v};
	endfunction

	function automatic logic [31:0] shr(input logic [31:0] v, input logic [2:0] n,
		input logic sgn);
		logic signed [32:0] t;
		t = $signed({sgn & v[31], v}) >>> (int'(n) + 1);
		shr = t[31:0];
	endfunction

	//////////////////////////////////////////////////////////////////////
	// decode
	wire wr_ctrl1 = sfr_wr && sfr_addr == acs_pkg::ADDR_CTRL1;
	wire wr_declo = sfr_wr && sfr_addr == acs_pkg::ADDR_DEC_LO;
	wire wr_dechi = sfr_wr && sfr_addr == acs_pkg::ADDR_DEC_HI;
	wire wr_ssctl = sfr_wr && sfr_addr == acs_pkg::ADDR_SSCTL;
	wire wr_sum0  = sfr_wr && sfr_addr == acs_pkg::ADDR_SUM0;
	wire wr_sum1  = sfr_wr && sfr_addr == acs_pkg::ADDR_SUM1;
	wire wr_sum2  = sfr_wr && sfr_addr == acs_pkg::ADDR_SUM2;
	wire wr_sum3  = sfr_wr && sfr_addr == acs_pkg::ADDR_SUM3;
	wire wr_input_offset_code  = sfr_wr && sfr_addr == acs_pkg::ADDR_INPUT_OFFSET_CODE;
	wire rd_sum0  = sfr_rd && sfr_addr == acs_pkg::ADDR_SUM0;
	wire [1:0] mode = ssctl_q[acs_pkg::MODE_LSB +: 2];
	wire [2:0] scnt = ssctl_q[acs_pkg::CNT_LSB +: 3];
	wire [2:0] shf  = ssctl_q[2:0];
	wire cpu_add = mode == acs_pkg::MODE_CPU && scnt == acs_pkg::CNT_CPU_ADD && shf == 3'h0;
	wire cpu_sub = mode == acs_pkg::MODE_CPU && scnt == acs_pkg::CNT_CPU_SUB && shf == 3'h0;
	wire conv_mode = mode == acs_pkg::MODE_CONV || mode == acs_pkg::MODE_BOTH;
	wire [8:0] cnt_target = 9'(9'h002 << scnt);
	wire [31:0] cpu_word = {acc_q[31:8], sfr_wdata};
	// the short variant carries its sign in bit 15, not bit 23
	wire sign_raw = short_variant ? res_q[15] : res_q[23];
	wire neg_res = !polarity_q && sign_raw;
	// unipolar clamps negative input to zero; short variant sign-extended
	wire [23:0] res_coded = (polarity_q && sign_raw) ? 24'h000000 : res_q;
	wire [31:0] res_word = short_variant ?
		{{16{neg_res}}, res_coded[15:0]} : {{8{neg_res}}, res_coded};
	wire hit = sfr_addr == acs_pkg::ADDR_CTRL1 || sfr_addr == acs_pkg::ADDR_DEC_LO
		|| sfr_addr == acs_pkg::ADDR_DEC_HI || (sfr_addr >= acs_pkg::ADDR_SSCTL
		&& sfr_addr <= acs_pkg::ADDR_INPUT_OFFSET_CODE);

	//////////////////////////////////////////////////////////////////////
	// rate generator
	acs_rate_gen u_rate (
		.mclk       (mclk),
		.rst        (rst),
		.enable     (!adc_powerdown),
		.aclk_div   (aclk_div),
		.decimation ({dec_hi_q, dec_lo_q}),
		.mod_tick   (),
		.data_tick  (data_tick)
	);

	//////////////////////////////////////////////////////////////////////
	// accumulator next value; 33-bit sum catches range errors
	always_comb begin
		logic [32:0] s;
		s         = 33'h000000000;
		acc_d     = acc_q;
		acc_err_d = 1'b0;
		if (wr_ssctl && sfr_wdata == 8'h00) begin
			acc_d = 32'h00000000;
		end else if (wr_sum0 && (cpu_add || cpu_sub)) begin
			if (cpu_add) begin
				s = ext33(acc_q, !polarity_q) + ext33(cpu_word, !polarity_q);
			end else begin
				s = ext33(acc_q, !polarity_q) - ext33(cpu_word, !polarity_q);
			end
			acc_d = s[31:0];
			acc_err_d = polarity_q ? s[32] : (s[32] != s[31]);
		end else if (wr_sum0 || wr_sum1 || wr_sum2 || wr_sum3) begin
			acc_d[7:0]   = wr_sum0 ? sfr_wdata : acc_q[7:0];
			acc_d[15:8]  = wr_sum1 ? sfr_wdata : acc_q[15:8];
			acc_d[23:16] = wr_sum2 ? sfr_wdata : acc_q[23:16];
			acc_d[31:24] = wr_sum3 ? sfr_wdata : acc_q[31:24];
		end else if (shift_pend_q) begin
			acc_d = shr(acc_q, shf, !polarity_q);
		end else if (res_valid_q && conv_mode && !sum_done_q && !wr_ssctl) begin
			s = ext33(acc_q, !polarity_q) + ext33(res_word, !polarity_q);
			acc_d = s[31:0];
			acc_err_d = polarity_q ? s[32] : (s[32] != s[31]);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			polarity_q <= acs_pkg::RST_CTRL1[acs_pkg::BIT_POLARITY];
			settle_q   <= acs_pkg::RST_CTRL1[acs_pkg::SETTLE_LSB +: 2];
			dec_lo_q   <= acs_pkg::RST_DEC_LO;
			dec_hi_q   <= acs_pkg::RST_DEC_HI;
			ssctl_q    <= acs_pkg::RST_SSCTL;
			input_offset_code_q     <= acs_pkg::RST_INPUT_OFFSET_CODE;
			cal_start  <= 1'b0;
			calibration_command <= 3'h0;
		end else begin
			cal_start <= wr_ctrl1;
			if (wr_ctrl1) begin
				polarity_q <= sfr_wdata[acs_pkg::BIT_POLARITY];
				settle_q   <= sfr_wdata[acs_pkg::SETTLE_LSB +: 2];
				calibration_command <= sfr_wdata[2:0];
			end
			if (wr_declo) dec_lo_q <= sfr_wdata;
			if (wr_dechi) dec_hi_q <= sfr_wdata[2:0];
			if (wr_ssctl) ssctl_q <= sfr_wdata;
			if (wr_input_offset_code) input_offset_code_q <= sfr_wdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// accumulator, counter and flags; held while converter is off
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_q        <= 32'h00000000;
			range_err_q  <= 1'b0;
			cnt_q        <= 9'h000;
			sum_done_q   <= 1'b0;
			shift_pend_q <= 1'b0;
			sum_irq      <= 1'b0;
			res_valid_q  <= 1'b0;
			res_q        <= 24'h000000;
		end else if (!adc_powerdown) begin
			res_valid_q <= result_valid;
			res_q       <= result_raw;
			acc_q       <= acc_d;
			// set beats the software clear
			if (acc_err_d) begin
				range_err_q <= 1'b1;
			end else if (wr_ctrl1 && !sfr_wdata[acs_pkg::BIT_RANGE_ERR]) begin
				range_err_q <= 1'b0;
			end
			shift_pend_q <= 1'b0;
			if (wr_ssctl) begin
				cnt_q        <= 9'h000;
				sum_done_q   <= 1'b0;
				shift_pend_q <= sfr_wdata[acs_pkg::MODE_LSB +: 2] == acs_pkg::MODE_SHIFT;
			end else if (res_valid_q && conv_mode && !sum_done_q && !shift_pend_q
				&& !(wr_sum0 || wr_sum1 || wr_sum2 || wr_sum3)) begin
				cnt_q <= cnt_q + 9'h001;
				if (cnt_q + 9'h001 == cnt_target) begin
					sum_done_q   <= 1'b1;
					shift_pend_q <= mode == acs_pkg::MODE_BOTH;
				end
			end
			// completion wins over a simultaneous clearing read
			if (res_valid_q && conv_mode && !sum_done_q && !shift_pend_q
				&& cnt_q + 9'h001 == cnt_target && !wr_ssctl
				&& !(wr_sum0 || wr_sum1 || wr_sum2 || wr_sum3)) begin
				sum_irq <= 1'b1;
			end else if (rd_sum0) begin
				sum_irq <= 1'b0;
			end
		end else begin
			// a result pending at power-down must not be added after wake-up
			res_valid_q <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// read mux and registered outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			sfr_rdata        <= 8'h00;
			sfr_hit          <= 1'b0;
			settling_select  <= 2'h0;
			decimation_ratio <= 11'h000;
			conv_tick        <= 1'b0;
			offset_code      <= 8'h00;
			offset_enable    <= 1'b0;
			result_top_byte  <= 8'h00;
		end else begin
			sfr_hit <= sfr_rd && hit;
			unique case (sfr_addr)
				acs_pkg::ADDR_CTRL1: sfr_rdata <= {range_err_q, polarity_q, settle_q, 4'h0};
				acs_pkg::ADDR_DEC_LO: sfr_rdata <= dec_lo_q;
				acs_pkg::ADDR_DEC_HI: sfr_rdata <= {5'h00, dec_hi_q};
				acs_pkg::ADDR_SSCTL: sfr_rdata <= ssctl_q;
				acs_pkg::ADDR_SUM0: sfr_rdata <= acc_q[7:0];
				acs_pkg::ADDR_SUM1: sfr_rdata <= acc_q[15:8];
				acs_pkg::ADDR_SUM2: sfr_rdata <= acc_q[23:16];
				acs_pkg::ADDR_SUM3: sfr_rdata <= acc_q[31:24];
				acs_pkg::ADDR_INPUT_OFFSET_CODE: sfr_rdata <= input_offset_code_q;
				default: sfr_rdata <= 8'h00;
			endcase
			settling_select  <= settle_q;
			decimation_ratio <= {dec_hi_q, dec_lo_q};
			conv_tick        <= data_tick;
			offset_code      <= input_offset_code_q;
			offset_enable    <= input_offset_code_q != acs_pkg::INPUT_OFFSET_CODE_OFF_POS
				&& input_offset_code_q != acs_pkg::INPUT_OFFSET_CODE_OFF_NEG;
			result_top_byte  <= short_variant ? {8{neg_res}} : res_coded[23:16];
		end
	end
endmodule
`default_nettype wire

// ===== tb/acs_properties.sv
// concurrent checks on the summation unit's ports
// assumes binding into acs_top, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module acs_properties (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// sfr port
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        sfr_hit,
	// converter side and outputs
	input wire logic        adc_powerdown,
	input wire logic        result_valid,
	input wire logic [1:0]  settling_select,
	input wire logic [2:0]  calibration_command,
	input wire logic        cal_start,
	input wire logic [10:0] decimation_ratio,
	input wire logic        offset_enable,
	input wire logic        sum_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// decoded accesses
	wire logic map = sfr_addr inside {[8'hDD:8'hDF], [8'hE1:8'hE6]};
	wire logic w_c1 = sfr_wr && sfr_addr == 8'hDD;
	wire logic w_dl = sfr_wr && sfr_addr == 8'hDE;
	wire logic w_od = sfr_wr && sfr_addr == 8'hE6;
	wire logic r_s0 = sfr_rd && sfr_addr == 8'hE2;
	// clear then read; no result may be in flight
	sequence s_clr; sfr_wr && sfr_addr == 8'hE1 && sfr_wdata == 8'h00 && !adc_powerdown; endsequence
	sequence s_gap; !sfr_wr && !adc_powerdown; endsequence
	sequence s_rd0; r_s0 && !sfr_wr && !result_valid; endsequence
	////////////////////////////////////////
	property p_cal; w_c1 |=> cal_start && calibration_command == $past(sfr_wdata[2:0]); endproperty
	a_cal: assert property (p_cal) else $error("calibration start wrong");
	property p_set; w_c1 ##1 !w_c1 |=> settling_select == $past(sfr_wdata[5:4], 2); endproperty
	a_set: assert property (p_set) else $error("settling select wrong");
	// latency of one or two cycles both pass
	property p_dec; w_dl ##1 !w_dl |=> decimation_ratio[7:0] == $past(sfr_wdata, 2); endproperty
	a_dec: assert property (p_dec) else $error("decimation low wrong");
	property p_ofs; w_od ##1 !w_od |=> offset_enable == ($past(sfr_wdata[6:0], 2) != 7'h00); endproperty
	a_ofs: assert property (p_ofs) else $error("offset enable wrong");
	property p_hit; sfr_rd |=> sfr_hit == $past(map); endproperty
	a_hit: assert property (p_hit) else $error("read hit wrong");
	property p_iclr; r_s0 && !sfr_wr && !result_valid && !$past(result_valid) |=> !sum_irq; endproperty
	a_iclr: assert property (p_iclr) else $error("interrupt not cleared");
	property p_ihold; sum_irq && !sfr_rd && !sfr_wr |=> sum_irq; endproperty
	a_ihold: assert property (p_ihold) else $error("interrupt dropped");
	property p_clr; s_clr ##1 s_gap ##1 s_rd0 |=> sfr_rdata == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("accumulator not cleared");
endmodule
bind acs_top acs_properties i_chk (.mclk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
	.sfr_rdata, .sfr_hit, .adc_powerdown, .result_valid, .settling_select,
	.calibration_command, .cal_start, .decimation_ratio, .offset_enable, .sum_irq);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the converter control and summation unit
// assumes acs_top with its checker bound, clock at 250 MHz
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic        adc_powerdown = 1'b0;
	logic        short_variant = 1'b0;
	logic [7:0]  aclk_div = 8'h01;
	logic        result_valid = 1'b0;
	logic [23:0] result_raw = 24'h000000;
	logic [7:0]  sfr_rdata, result_top_byte, offset_code, b;
	logic        sfr_hit, cal_start, conv_tick, offset_enable, sum_irq;
	logic [1:0]  settling_select;
	logic [2:0]  calibration_command, c, s;
	logic [10:0] decimation_ratio;
	logic [31:0] m, g, d;
	int          err_total = 0, n_tests = 0, seed = 32'h1A07, i, j, k, n;
	// reset table, unmapped address last
	logic [7:0]  ra [10] = '{8'hDD, 8'hDE, 8'hDF, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE0};
	logic [7:0]  rv [10] = '{8'h00, 8'h1B, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	acs_top i_dut (.mclk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
		.adc_powerdown, .short_variant, .aclk_div, .result_valid, .result_raw,
		.settling_select, .calibration_command, .cal_start, .decimation_ratio, .conv_tick,
		.offset_code, .offset_enable, .result_top_byte, .sum_irq);
	always #2 mclk = ~mclk;
	////////////////////////////////////////
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bus tasks leave an idle cycle so no strobe is set twice in a step
	task put(input logic [7:0] a, dv);
		@(posedge mclk);
		#1 sfr_addr = a;
		sfr_wdata = dv;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1 sfr_wr = 1'b0;
	endtask
	task get(input logic [7:0] a);
		@(posedge mclk);
		#1 sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge mclk);
		#1 sfr_rd = 1'b0;
		b = sfr_rdata;
	endtask
	task acc;
		for (int q = 0; q < 4; q++) begin
			get(8'hE2 + q[7:0]);
			g[8*q +: 8] = b;
		end
	endtask
	task res(input logic [23:0] r);
		@(posedge mclk);
		#1 result_raw = r;
		result_valid = 1'b1;
		@(posedge mclk);
		#1 result_valid = 1'b0;
	endtask
	// cycles up to the next output-rate strobe, bounded
	task wt;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (conv_tick !== 1'b1 && n < 1000);
	endtask
	function automatic logic [31:0] sx(logic [23:0] r, logic u);
		return u ? {8'h00, r} : {{8{r[23]}}, r};
	endfunction
	function automatic logic [31:0] shr(logic [31:0] v, logic [2:0] t, logic u);
		return u ? v >> ({1'b0, t} + 4'h1) : $unsigned($signed(v) >>> ({1'b0, t} + 4'h1));
	endfunction
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////
	// watchdog, far beyond the fewer than two thousand cycles needed
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1 rst = 1'b0;
		foreach (ra[q]) begin
			get(ra[q]);
			chk(b, rv[q]);
			chk(sfr_hit, ra[q] != 8'hE0);
		end
		chk(decimation_ratio, 11'h61B);
		$display("reset test done");
		// decimation set before the first modulator period ends
		d = $random(seed);
		put(8'hDE, d[7:0]);
		put(8'hDF, d[15:8]);
		@(posedge mclk);
		#1 chk(decimation_ratio, d[10:0]);
		put(8'hDE, 8'h02);
		put(8'hDF, 8'h00);
		wt;
		wt;
		chk(n, 64 * (aclk_div + 1) * 2);
		$display("rate test done");
		for (i = 0; i < 8; i++) begin
			d = $random(seed) & 32'h70 | i;
			put(8'hDD, d[7:0]);
			chk(cal_start, 1'b1);
			chk(calibration_command, i[2:0]);
			get(8'hDD);
			chk(settling_select, d[5:4]);
			chk(cal_start, 1'b0);
			chk(b & 8'h77, d[7:0] & 8'h70);
		end
		for (i = 0; i < 3; i++) begin
			d = (i == 0) ? 32'h00 : (i == 1) ? 32'h80 : $random(seed);
			put(8'hE6, d[7:0]);
			@(posedge mclk);
			#1 chk(offset_enable, d[6:0] != 7'h00);
			chk(offset_code, d[7:0]);
		end
		$display("control test done");
		// cpu add, subtract, then a forced signed overflow
		put(8'hDD, 8'h00);
		put(8'hE1, 8'h00);
		put(8'hE1, 8'h10);
		d = $random(seed) & 32'h1FFFFFFF;
		for (i = 1; i < 4; i++) put(8'hE2 + i[7:0], d[8*i +: 8]);
		put(8'hE2, d[7:0]);
		m = {d[31:8], 8'h00} + d;
		acc;
		chk(g, m);
		put(8'hE1, 8'h20);
		k = $random(seed);
		put(8'hE2, k[7:0]);
		m = m - {m[31:8], k[7:0]};
		acc;
		chk(g, m);
		put(8'hE1, 8'h10);
		put(8'hE5, 8'h40);
		put(8'hE2, 8'h00);
		get(8'hDD);
		chk(b[7], 1'b1);
		put(8'hDD, 8'h00);
		get(8'hDD);
		chk(b[7], 1'b0);
		$display("cpu test done");
		// both polarities, summing with and without the shift
		for (k = 0; k < 4; k++) begin
			put(8'hDD, {1'b0, k[0], 6'h00});
			put(8'hE1, 8'h00);
			get(8'hE2);
			chk(b, 8'h00);
			d = $random(seed);
			c = (k == 3) ? 3'h7 : {1'b0, d[1:0]};
			s = d[4:2];
			n = 2 << c;
			m = 0;
			put(8'hE1, {k[1], 1'b1, c, s});
			adc_powerdown = 1'b1;
			res(d[31:8]);
			repeat (3) @(posedge mclk);
			#1 adc_powerdown = 1'b0;
			for (j = 0; j < n; j++) begin
				d = $random(seed);
				if (k[0]) d[23] = 1'b0;
				res(d[23:0]);
				m = m + sx(d[23:0], k[0]);
				@(posedge mclk);
				#1 chk(sum_irq, j == n - 1);
			end
			chk(result_top_byte, d[23:16]);
			if (k[1]) m = shr(m, s, k[0]);
			acc;
			chk(g, m);
			chk(sum_irq, 1'b0);
			put(8'hE1, {2'b10, 3'h0, s});
			m = shr(m, s, k[0]);
			acc;
			chk(g, m);
		end
		$display("summation test done");
		put(8'hE1, 8'h00);
		short_variant = 1'b1;
		for (k = 0; k < 4; k++) begin
			put(8'hDD, {1'b0, k[0], 6'h00});
			d = $random(seed);
			d[15] = k[1];
			res(d[23:0]);
			repeat (2) @(posedge mclk);
			#1 chk(result_top_byte, (k[1] && !k[0]) ? 8'hFF : 8'h00);
		end
		$display("short variant test done");
		end_of_test;
	end
endmodule
`default_nettype wire
